// *** bench/dsra_host.sv ***
// host controller model for the shared link pins
`timescale 1ns/100ps
module dsra_host (
  // pins toward the device
  output logic      sck,
  output logic      sel_n,
  output logic      h_o,
  input  wire logic serial_out_line,
  input  wire logic line
);
  // clock stands high between frames
  initial begin
    sck = 1;
    sel_n = 1;
    h_o = 1;
  end
  // 4-wire bit: shift on fall, sdo taken at the rise
  task automatic bit4(input logic b, output logic s);
    sck <= 0;
    h_o <= b;
    #32 sck <= 1;
    s = serial_out_line;
    #32;
  endtask
  // whole frame, optional partial tail byte
  task automatic fw(input logic [7:0] q[$], input int part, output logic [7:0] r[$]);
    logic s;
    logic [7:0] v;
    r = {};
    sel_n <= 0;
    #32;
    foreach (q[i]) begin
      for (int k = 0; k < 8; k++) begin
        bit4(q[i][k], s);
        v[k] = s;
      end
      if (i > 1) r.push_back(v);
    end
    for (int k = 0; k < part; k++) bit4(1'b1, s);
    sel_n <= 1;
    h_o <= ~h_o; // stale line never looks valid
    #300;
  endtask
  // i2c bit: data moves only while scl low
  task automatic ibit(input logic b, output logic s);
    h_o <= b;
    #32 sck <= 1;
    #16 s = line;
    #16 sck <= 0;
  endtask
  task automatic istart;
    h_o <= 1;
    #32 sck <= 1;
    #16 h_o <= 0;
    #16 sck <= 0;
  endtask
  task automatic istop;
    h_o <= 0;
    #32 sck <= 1;
    #16 h_o <= 1;
    #64;
  endtask
  // byte msb first, ninth bit released or driven by host
  task automatic ibyte(input logic [7:0] b, input logic a, output logic [7:0] r, output logic n);
    for (int k = 7; k >= 0; k--) ibit(b[k], r[k]);
    ibit(a, n);
  endtask
  // start then bytes; select stays high
  task automatic ix(input logic [7:0] q[$], output logic [7:0] r, output logic n);
    logic a;
    istart;
    n = 0;
    foreach (q[i]) begin
      ibyte(q[i], 1'b1, r, a);
      n |= a;
    end
  endtask
endmodule // dsra_host

// *** bench/dsra_properties.sv ***
// checker of the link pins of the register access block
`timescale 1ns/100ps
module dsra_properties (
  // watched top ports
  input wire logic       CLK,
  input wire logic       NRST,
  input wire logic       SERIAL_CLK,
  input wire logic       SERIAL_SELECT_LOW,
  input wire logic       SERIAL_DATA_O,
  input wire logic       SERIAL_DATA_OE_N,
  input wire logic       SERIAL_OUT_LINE,
  input wire logic       REFLECTION_HOLD,
  input wire logic [1:0] LINK_MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // select parked high long enough for the sync to settle
  sequence sel_idle;
    SERIAL_SELECT_LOW [*8];
  endsequence
  // link clock high inside a 4-wire frame
  sequence sck_high;
    (!SERIAL_SELECT_LOW && SERIAL_CLK) [*6];
  endsequence
  AST_MODE_LOCK: assert property (LINK_MODE != 2'h0 |=> $stable(LINK_MODE))
    else $error("link mode moved");
  AST_MODE_LEGAL: assert property (LINK_MODE != 2'h3)
    else $error("link mode code");
  AST_OE_FOUR: assert property (LINK_MODE == 2'h1 |-> SERIAL_DATA_OE_N)
    else $error("sda pulled in 4-wire");
  AST_OE_SEL: assert property (!SERIAL_DATA_OE_N |-> SERIAL_SELECT_LOW)
    else $error("sda pulled with select low");
  AST_OE_SCL_LOW: assert property ($changed(SERIAL_DATA_OE_N) |-> !SERIAL_CLK)
    else $error("sda moved with scl high");
  AST_SDO_IDLE: assert property (sel_idle |-> !SERIAL_OUT_LINE)
    else $error("sdo busy outside frame");
  AST_SDO_STEADY: assert property (sck_high |-> $stable(SERIAL_OUT_LINE))
    else $error("sdo moved with sck high");
  AST_HOLD_I2C: assert property ($changed(REFLECTION_HOLD) |-> LINK_MODE == 2'h2)
    else $error("hold moved outside i2c");
  AST_DATA_O_LOW: assert property (SERIAL_DATA_O == 1'b0)
    else $error("sda drive value high");
endmodule // dsra_properties
bind dsra_serial_access dsra_properties u_dsra_properties (.CLK, .NRST, .SERIAL_CLK, .SERIAL_SELECT_LOW,
  .SERIAL_DATA_O, .SERIAL_DATA_OE_N, .SERIAL_OUT_LINE, .REFLECTION_HOLD, .LINK_MODE);

// *** bench/dual_serial_register_access_bench.sv ***
// bench of the dual serial register access block
`timescale 1ns/100ps
`include "dsra_cfg.svh"
module dual_serial_register_access_bench;
  logic       clk, nrst, vs_n, sck, sel_n, h_o, serial_out_line, oe_n, dout, hold, nak;
  logic [8:0] idx;
  logic [7:0] rdat, v, d[4];
  logic [7:0] r[$];
  logic [1:0] mode;
  int         n_mismatch, n_tests;
  wire        line = oe_n ? h_o : (h_o & dout); // pulled-up sda
  dsra_host u_dsra_host (.sck(sck), .sel_n(sel_n), .h_o(h_o), .serial_out_line(serial_out_line), .line(line));
  dsra_serial_access u_dsra_serial_access (.CLK(clk), .NRST(nrst), .SERIAL_CLK(sck),
    .SERIAL_SELECT_LOW(sel_n), .SERIAL_IN_LINE(line), .SERIAL_DATA_O(dout), .SERIAL_DATA_OE_N(oe_n),
    .SERIAL_OUT_LINE(serial_out_line), .VERTICAL_SYNC_LOW(vs_n), .REFL_IDX(idx), .REFL_DATA(rdat),
    .REFLECTION_HOLD(hold), .LINK_MODE(mode));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // reflected copy after a boundary: a held bank keeps the old value
  function automatic logic [7:0] exp_refl(input logic held, input logic [7:0] old_v, input logic [7:0] new_v);
    return held ? old_v : new_v;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rst;
    @(posedge clk) nrst <= 0;
    repeat (16) @(posedge clk);
    nrst <= 1;
    repeat (8) @(posedge clk);
  endtask
  // one frame boundary; vs_n held low for 8 clocks, then high for 8
  task automatic vs;
    @(posedge clk) vs_n <= 0;
    repeat (8) @(posedge clk);
    vs_n <= 1;
    repeat (8) @(posedge clk);
  endtask
  task automatic rf(input logic [8:0] i, input logic [7:0] e, input string s);
    @(posedge clk) idx <= i;
    repeat (3) @(posedge clk);
    #1 chk(s, rdat, e);
  endtask
  task automatic wi(input logic [7:0] q[$]);
    u_dsra_host.ix(q, v, nak);
    u_dsra_host.istop;
    chk("ack", {7'h00, nak}, 8'h00);
  endtask
  initial begin
    #300000 n_mismatch++;
    final_report;
  end
  initial begin
    nrst = 0;
    vs_n = 1;
    idx = 9'h000;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(32'hbed2));
    foreach (d[i]) d[i] = 8'($urandom);
    rst;
    // 4-wire: write wraps from ff to 00, echo shows old values
    u_dsra_host.fw({`DSRA_PAGE_WR_A, 8'hff, d[0], d[1]}, 0, r);
    chk("echo0", r[0], 8'h00);
    chk("echo1", r[1], `DSRA_RST_IMMEDIATE);
    chk("mode", {6'h00, mode}, 8'h01);
    rf(9'h000, d[1], "imm");
    rf(9'h0ff, 8'h00, "frm");
    u_dsra_host.fw({`DSRA_PAGE_WR_B, 8'h05, d[2]}, 3, r);
    u_dsra_host.fw({8'h42, 8'hff, 8'h5a}, 0, r);
    chk("bad", r[0], 8'h00);
    u_dsra_host.fw({`DSRA_PAGE_RD_A, 8'hff, 8'h5a, d[3]}, 0, r);
    chk("rd0", r[0], d[0]);
    chk("rd1", r[1], d[1]);
    u_dsra_host.fw({`DSRA_PAGE_RD_B, 8'h05, 8'h00, 8'h00}, 0, r);
    chk("rdb", r[0], d[2]);
    chk("part", r[1], 8'h00);
    u_dsra_host.fw({`DSRA_PAGE_WR_A, 8'h20, d[3]}, 0, r);
    vs;
    rf(9'h0ff, d[0], "refl");
    rf(9'h020, 8'h00, "int1");
    vs;
    rf(9'h020, d[3], "int2");
    u_dsra_host.ix({8'h34}, v, nak);
    u_dsra_host.istop;
    chk("lock", {7'h00, nak}, 8'h01);
    // i2c after a fresh reset
    rst;
    wi({8'h34, 8'h01, 8'h04, 8'h01});
    chk("hold", {7'h00, hold}, 8'h01);
    wi({8'h34, 8'h30, 8'h10, d[0], d[1]});
    vs;
    rf(9'h010, exp_refl(1'b1, 8'h00, d[0]), "held");
    wi({8'h34, 8'h01, 8'h04, 8'h00});
    vs;
    rf(9'h011, exp_refl(1'b0, 8'h00, d[1]), "rel");
    chk("mode2", {6'h00, mode}, 8'h02);
    // a 4-wire write once i2c is chosen must leave 3010h untouched
    u_dsra_host.fw({`DSRA_PAGE_WR_A, 8'h10, ~d[0]}, 0, r);
    u_dsra_host.ix({8'h34, 8'h30, 8'h10}, v, nak);
    u_dsra_host.ix({8'h35}, v, nak);
    u_dsra_host.ibyte(8'hff, 1'b0, v, nak);
    chk("i2crd", v, d[0]);
    u_dsra_host.ibyte(8'hff, 1'b1, v, nak);
    u_dsra_host.istop;
    chk("i2cseq", v, d[1]);
    u_dsra_host.ix({8'h36}, v, nak);
    u_dsra_host.istop;
    chk("addr", {7'h00, nak}, 8'h01);
    final_report;
  end
endmodule // dual_serial_register_access_bench

// *** src/dsra_cfg.svh ***
// constants of the dual serial register access block
`ifndef DSRA_CFG_SVH
`define DSRA_CFG_SVH
// ----------------------------------------------------------------
// 4-wire page codes
// ----------------------------------------------------------------
`define DSRA_PAGE_WR_A     8'h02
`define DSRA_PAGE_WR_B     8'h03
`define DSRA_PAGE_RD_A     8'h82
`define DSRA_PAGE_RD_B     8'h83
// ----------------------------------------------------------------
// i2c and register map
// ----------------------------------------------------------------
`define DSRA_SLAVE_ADDR    7'h1a
`define DSRA_HOLD_ADDR     16'h0104
`define DSRA_HOLD_BIT      0
`define DSRA_BANK_BASE     16'h3000
`define DSRA_BANK_LAST     16'h31ff
`define DSRA_BANK_WORDS    512
`define DSRA_IDX_IMMEDIATE 9'h000
`define DSRA_RST_IMMEDIATE 8'h01
`define DSRA_IDX_INTEG_HI  9'h020
`define DSRA_IDX_INTEG_LO  9'h021
`define DSRA_LAST_BIT      3'h7
`define DSRA_FULL_BYTE     4'h8
`endif

// *** src/dsra_pkg.sv ***
// types and decode helpers of the dual serial register access block
package dsra_pkg;
`include "dsra_cfg.svh"

  // ----------------------------------------------------------------
  // link choice and i2c states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DSRA_MODE_NONE = 2'b00,
    DSRA_MODE_FOUR = 2'b01,
    DSRA_MODE_I2C  = 2'b10
  } dsra_mode_t;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_DEV  = 3'b001,
    I2C_AHI  = 3'b010,
    I2C_ALO  = 3'b011,
    I2C_WR   = 3'b100,
    I2C_RD   = 3'b101,
    I2C_IGN  = 3'b110
  } dsra_i2c_st_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } dsra_wreq_t;

  typedef struct packed {
    logic clk;
    logic din;
    logic sel_n;
    logic vs_n;
  } dsra_pins_t;

  // 4-wire page/address to the common 16-bit register address
  function automatic logic [15:0] dsra_map4w(input logic [7:0] page, input logic [7:0] addr);
    return `DSRA_BANK_BASE | {7'h00, page[0], addr};
  endfunction

  // address falls inside the stored bank
  function automatic logic dsra_in_bank(input logic [15:0] a);
    return (a >= `DSRA_BANK_BASE) && (a <= `DSRA_BANK_LAST);
  endfunction
endpackage

// *** src/dsra_regfile.sv ***
// register bank with live and reflected copies and the hold bit
`timescale 1ns/100ps
`include "dsra_cfg.svh"
module dsra_regfile import dsra_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // access from the link engines
  input  wire dsra_wreq_t  wreq,
  input  wire logic [15:0] rd_addr,
  output logic [7:0]       rd_data,
  // frame side
  input  wire logic        frame_tick,
  input  wire logic [8:0]  app_idx,
  output logic [7:0]       app_data,
  output logic             hold
);
  logic [7:0] live_r   [`DSRA_BANK_WORDS];  // as written by the host
  logic [7:0] live_nxt [`DSRA_BANK_WORDS];
  logic [7:0] refl_r   [`DSRA_BANK_WORDS];  // as seen by the sensor core
  logic [7:0] refl_nxt [`DSRA_BANK_WORDS];
  logic [7:0] integ_r  [2];                 // integration time, one frame behind
  logic [7:0] integ_nxt[2];
  logic       hold_r;
  logic       hold_nxt;

  // ----------------------------------------------------------------
  // next state: writes and frame reflection
  // ----------------------------------------------------------------
  always_comb begin
    live_nxt  = live_r;
    refl_nxt  = refl_r;
    integ_nxt = integ_r;
    hold_nxt  = hold_r;
    if (frame_tick && !hold_r) begin
      refl_nxt = live_r;
      // shutter takes the value after readout, so one more frame
      refl_nxt[`DSRA_IDX_INTEG_HI] = integ_r[0];
      refl_nxt[`DSRA_IDX_INTEG_LO] = integ_r[1];
      integ_nxt[0] = live_r[`DSRA_IDX_INTEG_HI];
      integ_nxt[1] = live_r[`DSRA_IDX_INTEG_LO];
    end
    if (wreq.en) begin
      if (wreq.addr == `DSRA_HOLD_ADDR) begin
        hold_nxt = wreq.data[`DSRA_HOLD_BIT];
      end else if (dsra_in_bank(wreq.addr)) begin
        live_nxt[wreq.addr[8:0]] = wreq.data;
        if (wreq.addr[8:0] == `DSRA_IDX_IMMEDIATE) begin
          refl_nxt[wreq.addr[8:0]] = wreq.data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `DSRA_BANK_WORDS; i++) begin
        live_r[i] <= 8'h00;
        refl_r[i] <= 8'h00;
      end
      live_r[`DSRA_IDX_IMMEDIATE] <= `DSRA_RST_IMMEDIATE;
      refl_r[`DSRA_IDX_IMMEDIATE] <= `DSRA_RST_IMMEDIATE;
      integ_r[0] <= 8'h00;
      integ_r[1] <= 8'h00;
      hold_r     <= 1'b0;
    end else begin
      live_r  <= live_nxt;
      refl_r  <= refl_nxt;
      integ_r <= integ_nxt;
      hold_r  <= hold_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read ports; unmapped addresses read zero
  // ----------------------------------------------------------------
  always_comb begin
    if (rd_addr == `DSRA_HOLD_ADDR) begin
      rd_data = {7'h00, hold_r};
    end else if (dsra_in_bank(rd_addr)) begin
      rd_data = live_r[rd_addr[8:0]];
    end else begin
      rd_data = 8'h00;
    end
  end
  assign app_data = refl_r[app_idx];
  assign hold     = hold_r;
endmodule // dsra_regfile

// *** src/dsra_serial_access.sv ***
// dual 4-wire / i2c register access front end
`timescale 1ns/100ps
`include "dsra_cfg.svh"
// Function
// - first transaction picks link, locked until reset
// - 4-wire bytes travel lsb first both ways
// - page codes 02/03 write, 82/83 read
// - unknown page code ignores rest of frame
// - host shifts on fall, device samples rise
// - write stores from start address, auto increment
// - only whole received bytes are committed
// - write echoes old register values on output
// - read dummies not stored, contents shifted out
// - select low opens, high ends transaction
// - frame settings at frame, immediate ones at once
// - integration time reaches output one frame later
// - hold bit freezes reflection except immediate index 000, clearing releases all
// - i2c bytes msb first, each then acknowledged
// - slave address 0011010, then direction bit
// - i2c carries two address bytes then data
// - start is data fall with clock high
// - sender releases data line in acknowledge bit
// - i2c index loaded, steps at each data acknowledge
module dsra_serial_access import dsra_pkg::*; (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       NRST,
  // shared serial link pins
  input  wire logic       SERIAL_CLK,
  input  wire logic       SERIAL_SELECT_LOW,
  input  wire logic       SERIAL_IN_LINE,
  output logic            SERIAL_DATA_O,
  output logic            SERIAL_DATA_OE_N,
  output logic            SERIAL_OUT_LINE,
  // frame timing
  input  wire logic       VERTICAL_SYNC_LOW,
  // sensor core side
  input  wire logic [8:0] REFL_IDX,
  output logic [7:0]      REFL_DATA,
  output logic            REFLECTION_HOLD,
  output logic [1:0]      LINK_MODE
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic         rst_meta_r;      // reset release stages
  logic         rst_n_r;
  dsra_pins_t   pins_raw;        // pins before and after sync
  dsra_pins_t   pins_s;
  dsra_pins_t   prev_r;          // one cycle older, for edges
  logic         clk_rise, clk_fall, sel_fall, sel_rise, frame_tick;
  logic         i2c_start, i2c_stop;
  dsra_mode_t   mode_r, mode_4, mode_i;
  logic [2:0]   bit4_r, bit4_nxt;     // bit within 4-wire byte
  logic [1:0]   byte4_r, byte4_nxt;   // 0 page, 1 address, 2 data
  logic [7:0]   sh4_r, sh4_nxt;       // receive shifter
  logic [7:0]   page_r, page_nxt;
  logic [7:0]   addr4_r, addr4_nxt;
  logic         ign4_r, ign4_nxt;     // frame being ignored
  logic         load4_r, load4_nxt;   // fetch next echo byte
  logic [7:0]   out4_r, out4_nxt;     // byte being shifted out
  logic         sdo_r, sdo_nxt;
  logic [7:0]   byte_in;
  dsra_wreq_t   wreq_4, wreq_i, wreq;
  dsra_i2c_st_t ist_r, ist_nxt;
  logic [3:0]   icnt_r, icnt_nxt;     // bits of current i2c byte
  logic         ack_r, ack_nxt;       // in acknowledge bit
  logic [7:0]   ish_r, ish_nxt;
  logic [15:0]  idx_r, idx_nxt;       // i2c register index
  logic         rw_r, rw_nxt;
  logic         mack_r, mack_nxt;     // host acked our byte
  logic         iload_r, iload_nxt;   // drive first bit of read byte
  logic         oen_r, oen_nxt;       // open-drain enable, low drives
  logic [15:0]  rd_addr;
  logic [7:0]   rd_data, app_data;
  logic         hold;
  logic [7:0]   refl_r;

  // ----------------------------------------------------------------
  // reset release and pin synchronisation
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  assign pins_raw = '{clk: SERIAL_CLK, din: SERIAL_IN_LINE, sel_n: SERIAL_SELECT_LOW, vs_n: VERTICAL_SYNC_LOW};

  dsra_sync u_sync (
    .clk   (CLK),
    .rst_n (rst_n_r),
    .d     (pins_raw),
    .q     (pins_s)
  );

  // edge history of the synchronised pins
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prev_r <= 4'hf;
    end else begin
      prev_r <= pins_s;
    end
  end

  assign clk_rise   = pins_s.clk & ~prev_r.clk;
  assign clk_fall   = ~pins_s.clk & prev_r.clk;
  assign sel_fall   = ~pins_s.sel_n & prev_r.sel_n;
  assign sel_rise   = pins_s.sel_n & ~prev_r.sel_n;
  assign frame_tick = ~pins_s.vs_n & prev_r.vs_n;  // reflection point
  // data moves with clock high only for start and stop
  assign i2c_start  = pins_s.clk & prev_r.clk & prev_r.din & ~pins_s.din;
  assign i2c_stop   = pins_s.clk & prev_r.clk & ~prev_r.din & pins_s.din;
  assign byte_in    = {pins_s.din, sh4_r[7:1]};

  // ----------------------------------------------------------------
  // 4-wire engine
  // ----------------------------------------------------------------
  always_comb begin
    mode_4    = mode_r;
    bit4_nxt  = bit4_r;
    byte4_nxt = byte4_r;
    sh4_nxt   = sh4_r;
    page_nxt  = page_r;
    addr4_nxt = addr4_r;
    ign4_nxt  = ign4_r;
    load4_nxt = 1'b0;
    out4_nxt  = out4_r;
    sdo_nxt   = sdo_r;
    wreq_4    = '0;
    if (mode_r != DSRA_MODE_I2C) begin
      if (sel_fall) begin
        mode_4    = DSRA_MODE_FOUR;
        bit4_nxt  = 3'h0;
        byte4_nxt = 2'h0;
        ign4_nxt  = 1'b0;
        out4_nxt  = 8'h00;
        sdo_nxt   = 1'b0;
      end else if (sel_rise) begin
        // a byte cut short is simply dropped
        bit4_nxt  = 3'h0;
        byte4_nxt = 2'h0;
        // park the echo line low so no stale bit lingers between frames
        sdo_nxt   = 1'b0;
      end else if (!pins_s.sel_n) begin
        if (clk_rise) begin
          sh4_nxt  = byte_in;
          bit4_nxt = bit4_r + 3'h1;
          if (bit4_r == `DSRA_LAST_BIT) begin
            case (byte4_r)
              2'h0: begin
                page_nxt  = byte_in;
                ign4_nxt  = !(byte_in == `DSRA_PAGE_WR_A || byte_in == `DSRA_PAGE_WR_B ||
                              byte_in == `DSRA_PAGE_RD_A || byte_in == `DSRA_PAGE_RD_B);
                byte4_nxt = 2'h1;
              end
              2'h1: begin
                addr4_nxt = byte_in;
                byte4_nxt = 2'h2;
                load4_nxt = !ign4_r;
              end
              default: begin
                if (!ign4_r) begin
                  // write pages store; read pages drop the dummy
                  wreq_4.en   = !page_r[7];
                  wreq_4.addr = dsra_map4w(page_r, addr4_r);
                  wreq_4.data = byte_in;
                  addr4_nxt   = addr4_r + 8'h01;
                  load4_nxt   = 1'b1;
                end
              end
            endcase
          end
        end
        if (clk_fall) begin
          sdo_nxt = out4_r[bit4_r];
        end
      end
      // fetched one cycle after the address moves, before any write
      if (load4_r) begin
        out4_nxt = rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // i2c engine
  // ----------------------------------------------------------------
  always_comb begin
    mode_i    = mode_r;
    ist_nxt   = ist_r;
    icnt_nxt  = icnt_r;
    ack_nxt   = ack_r;
    ish_nxt   = ish_r;
    idx_nxt   = idx_r;
    rw_nxt    = rw_r;
    mack_nxt  = mack_r;
    iload_nxt = 1'b0;
    oen_nxt   = oen_r;
    wreq_i    = '0;
    // select low means the 4-wire link owns the pins
    if (mode_r != DSRA_MODE_FOUR && pins_s.sel_n) begin
      if (i2c_start) begin
        mode_i   = DSRA_MODE_I2C;
        ist_nxt  = I2C_DEV;
        icnt_nxt = 4'h0;
        ack_nxt  = 1'b0;
        oen_nxt  = 1'b1;
      end else if (i2c_stop) begin
        ist_nxt = I2C_IDLE;
        ack_nxt = 1'b0;
        oen_nxt = 1'b1;
      end else begin
        if (clk_rise && !ack_r && ist_r != I2C_IDLE && ist_r != I2C_IGN) begin
          ish_nxt  = {ish_r[6:0], pins_s.din};
          icnt_nxt = icnt_r + 4'h1;
        end
        if (clk_rise && ack_r && ist_r == I2C_RD) begin
          mack_nxt = ~pins_s.din;
        end
        if (iload_r) begin
          oen_nxt = rd_data[7];
        end
        if (clk_fall && !ack_r && icnt_r == `DSRA_FULL_BYTE) begin
          ack_nxt = 1'b1;
          oen_nxt = 1'b0;
          case (ist_r)
            I2C_DEV: begin
              if (ish_r[7:1] == `DSRA_SLAVE_ADDR) begin
                rw_nxt = ish_r[0];
              end else begin
                ist_nxt = I2C_IGN;
                ack_nxt = 1'b0;
                oen_nxt = 1'b1;
              end
            end
            I2C_AHI: idx_nxt[15:8] = ish_r;
            I2C_ALO: idx_nxt[7:0]  = ish_r;
            I2C_WR: begin
              wreq_i.en   = 1'b1;
              wreq_i.addr = idx_r;
              wreq_i.data = ish_r;
            end
            I2C_RD: oen_nxt = 1'b1;
            default: begin
              ack_nxt = 1'b0;
              oen_nxt = 1'b1;
            end
          endcase
        end else if (clk_fall && ack_r) begin
          ack_nxt  = 1'b0;
          icnt_nxt = 4'h0;
          oen_nxt  = 1'b1;
          case (ist_r)
            I2C_DEV: begin
              ist_nxt   = rw_r ? I2C_RD : I2C_AHI;
              iload_nxt = rw_r;
            end
            I2C_AHI: ist_nxt = I2C_ALO;
            I2C_ALO: ist_nxt = I2C_WR;
            I2C_WR:  idx_nxt = idx_r + 16'h0001;
            I2C_RD: begin
              idx_nxt   = idx_r + 16'h0001;
              iload_nxt = mack_r;
              // after a not-acknowledge wait for the host's stop
              ist_nxt   = mack_r ? I2C_RD : I2C_IGN;
            end
            default: ist_nxt = I2C_IGN;
          endcase
        end else if (clk_fall && ist_r == I2C_RD && icnt_r != 4'h0) begin
          oen_nxt = rd_data[3'(4'h7 - icnt_r)];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // shared register access
  // ----------------------------------------------------------------
  assign wreq    = wreq_4.en ? wreq_4 : wreq_i;
  assign rd_addr = (mode_r == DSRA_MODE_I2C) ? idx_r : dsra_map4w(page_r, addr4_r);

  dsra_regfile u_regs (
    .clk        (CLK),
    .rst_n      (rst_n_r),
    .wreq       (wreq),
    .rd_addr    (rd_addr),
    .rd_data    (rd_data),
    .frame_tick (frame_tick),
    .app_idx    (REFL_IDX),
    .app_data   (app_data),
    .hold       (hold)
  );

  // ----------------------------------------------------------------
  // state registers; link choice kept until reset
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r  <= DSRA_MODE_NONE;
      bit4_r  <= 3'h0;
      byte4_r <= 2'h0;
      sh4_r   <= 8'h00;
      page_r  <= 8'h00;
      addr4_r <= 8'h00;
      ign4_r  <= 1'b1;
      load4_r <= 1'b0;
      out4_r  <= 8'h00;
      sdo_r   <= 1'b0;
      ist_r   <= I2C_IDLE;
      icnt_r  <= 4'h0;
      ack_r   <= 1'b0;
      ish_r   <= 8'h00;
      idx_r   <= 16'h0000;
      rw_r    <= 1'b0;
      mack_r  <= 1'b0;
      iload_r <= 1'b0;
      oen_r   <= 1'b1;
      refl_r  <= 8'h00;
    end else begin
      // both engines are gated by mode, only one can move it
      mode_r  <= (mode_4 != mode_r) ? mode_4 : mode_i;
      bit4_r  <= bit4_nxt;
      byte4_r <= byte4_nxt;
      sh4_r   <= sh4_nxt;
      page_r  <= page_nxt;
      addr4_r <= addr4_nxt;
      ign4_r  <= ign4_nxt;
      load4_r <= load4_nxt;
      out4_r  <= out4_nxt;
      sdo_r   <= sdo_nxt;
      ist_r   <= ist_nxt;
      icnt_r  <= icnt_nxt;
      ack_r   <= ack_nxt;
      ish_r   <= ish_nxt;
      idx_r   <= idx_nxt;
      rw_r    <= rw_nxt;
      mack_r  <= mack_nxt;
      iload_r <= iload_nxt;
      oen_r   <= oen_nxt;
      refl_r  <= app_data;
    end
  end

  // outputs straight from flops, except SERIAL_DATA_O which is tied low
  assign SERIAL_DATA_O    = 1'b0;
  assign SERIAL_DATA_OE_N = oen_r;
  assign SERIAL_OUT_LINE  = sdo_r;
  assign REFL_DATA        = refl_r;
  assign REFLECTION_HOLD  = hold;
  assign LINK_MODE        = mode_r;
endmodule // dsra_serial_access

// *** src/dsra_sync.sv ***
// two flip-flop synchroniser for the link pins
`timescale 1ns/100ps
module dsra_sync import dsra_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // pins in, synchronised copy out
  input  wire dsra_pins_t d,
  output dsra_pins_t      q
);
  dsra_pins_t meta_r;  // first stage, read only by the second

  // ----------------------------------------------------------------
  // two stages; idle values are the released line levels
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 4'hf;
      q      <= 4'hf;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // dsra_sync
